// ===== hw/tmr_timer0.v
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "tmr_consts.vh"

module tmr_timer0 #(
  parameter PRESCALE_WIDTH = 10
) (
  input  wire                      pclk,
  input  wire                      presetn,
  input  wire                      psel,
  input  wire                      penable,
  input  wire                      pwrite,
  input  wire [7:0]                paddr,
  input  wire [31:0]               pwdata,
  output reg  [31:0]               prdata,
  output wire                      pready,
  output reg                       pslverr,
  input  wire                      ext_count_pin,
  input  wire                      global_irq_en,
  input  wire                      overflow_vector_ack,
  input  wire                      compare_vector_ack,
  output wire                      overflow_irq,
  output wire                      compare_irq,
  output reg                       compare_match,
  output reg  [7:0]                counter_value,
  output wire [`TMR_TAP_COUNT-1:0] prescale_taps,
  output wire                      shared_prescaler_reset,
  output wire                      async_prescaler_reset
);

  reg  [7:0]                compare_value;
  reg  [7:0]                timer_interrupt_mask;
  reg                       overflow_flag;
  reg                       compare_flag;
  reg  [2:0]                clock_selector;
  reg                       phase_correct;
  reg                       count_down;
  reg                       sync_hold_mode;
  reg                       shared_reset_bit;
  reg                       async_reset_bit;
  reg                       block_match;
  reg  [PRESCALE_WIDTH-1:0] prescale_count;
  reg                       pin_sync1;
  reg                       pin_sync2;
  reg                       pin_prev;
  reg  [7:0]                next_counter;
  reg                       next_count_down;
  reg                       next_overflow_event;
  reg  [31:0]               next_rdata;
  reg                       next_err;
  reg                       next_overflow_flag;
  reg                       next_compare_flag;
  reg                       next_hold;
  reg                       next_shared_reset;
  reg                       next_async_reset;
  wire                      setup_phase;
  wire                      wr_access;
  wire                      timer_tick;
  wire                      rise_edge;
  wire                      fall_edge;
  wire                      match_event;
  wire                      wr_count;
  wire                      wr_compare;
  wire                      wr_mask;
  wire                      wr_flags;
  wire                      wr_sfc;
  wire                      wr_ctrl;
  wire                      ovf_clear;
  wire                      cmp_clear;

  // tap pulse when the low bits of the free-running divider are all ones
  function tap_pulse;
    input [PRESCALE_WIDTH-1:0] cnt;
    input integer              width;
    integer                    i;
    begin
      tap_pulse = 1'b1;
      for (i = 0; i < PRESCALE_WIDTH; i = i + 1) begin
        if (i < width && !cnt[i]) begin
          tap_pulse = 1'b0;
        end
      end
    end
  endfunction

  // timer tick from selector, taps and external edges
  function select_tick;
    input [2:0]                    sel;
    input [`TMR_TAP_COUNT-1:0]     taps;
    input                          rise;
    input                          fall;
    begin
      case (sel)
        `TMR_SEL_STOP:     select_tick = 1'b0;
        `TMR_SEL_DIV1:     select_tick = taps[`TMR_TAP_1];
        `TMR_SEL_DIV8:     select_tick = taps[`TMR_TAP_8];
        `TMR_SEL_DIV64:    select_tick = taps[`TMR_TAP_64];
        `TMR_SEL_DIV256:   select_tick = taps[`TMR_TAP_256];
        `TMR_SEL_DIV1024:  select_tick = taps[`TMR_TAP_1024];
        `TMR_SEL_EXT_FALL: select_tick = fall;
        `TMR_SEL_EXT_RISE: select_tick = rise;
        default:           select_tick = 1'b0;
      endcase
    end
  endfunction

  // write strobe for one register, taken in the access phase
  function reg_write_hit;
    input       access;
    input [7:0] addr;
    input [7:0] target;
    begin
      reg_write_hit = access && (addr == target);
    end
  endfunction

  assign pready      = 1'b1;
  assign setup_phase = psel & ~penable;
  assign wr_access   = psel & penable & pwrite;

  // one write strobe per register
  assign wr_count    = reg_write_hit(wr_access, paddr, `TMR_ADDR_COUNT);
  assign wr_compare  = reg_write_hit(wr_access, paddr, `TMR_ADDR_COMPARE);
  assign wr_mask     = reg_write_hit(wr_access, paddr, `TMR_ADDR_MASK);
  assign wr_flags    = reg_write_hit(wr_access, paddr, `TMR_ADDR_FLAGS);
  assign wr_sfc      = reg_write_hit(wr_access, paddr, `TMR_ADDR_SFC);
  assign wr_ctrl     = reg_write_hit(wr_access, paddr, `TMR_ADDR_CTRL);

  // a flag clears by its vector acknowledge or by writing one to it
  assign ovf_clear   = overflow_vector_ack | (wr_flags & pwdata[`TMR_BIT_OVF]);
  assign cmp_clear   = compare_vector_ack | (wr_flags & pwdata[`TMR_BIT_CMP]);

  // shared divider, free running, restarted only by the reset bit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_count <= {PRESCALE_WIDTH{1'b0}};
    end else if (shared_reset_bit) begin
      prescale_count <= {PRESCALE_WIDTH{1'b0}};
    end else begin
      prescale_count <= prescale_count + 1'b1;
    end
  end

  // the held reset also stops the /1 tap so all timers clocked from the taps stay halted together
  assign prescale_taps[`TMR_TAP_1]    = ~shared_reset_bit;
  assign prescale_taps[`TMR_TAP_8]    = tap_pulse(prescale_count, `TMR_LOG_DIV8) & ~shared_reset_bit;
  assign prescale_taps[`TMR_TAP_16]   = tap_pulse(prescale_count, `TMR_LOG_DIV16) & ~shared_reset_bit;
  assign prescale_taps[`TMR_TAP_32]   = tap_pulse(prescale_count, `TMR_LOG_DIV32) & ~shared_reset_bit;
  assign prescale_taps[`TMR_TAP_64]   = tap_pulse(prescale_count, `TMR_LOG_DIV64) & ~shared_reset_bit;
  assign prescale_taps[`TMR_TAP_256]  = tap_pulse(prescale_count, `TMR_LOG_DIV256) & ~shared_reset_bit;
  assign prescale_taps[`TMR_TAP_1024] = tap_pulse(prescale_count, `TMR_LOG_DIV1024) & ~shared_reset_bit;

  assign shared_prescaler_reset = shared_reset_bit;
  assign async_prescaler_reset  = async_reset_bit;

  // pin is read whatever its direction, so driving it as an output still counts
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync1 <= 1'b0;
      pin_sync2 <= 1'b0;
      pin_prev  <= 1'b0;
    end else begin
      pin_sync1 <= ext_count_pin;
      pin_sync2 <= pin_sync1;
      pin_prev  <= pin_sync2;
    end
  end

  assign rise_edge  = pin_sync2 & ~pin_prev;
  assign fall_edge  = ~pin_sync2 & pin_prev;
  assign timer_tick = select_tick(clock_selector, prescale_taps, rise_edge, fall_edge);

  assign match_event = timer_tick && !block_match && (counter_value == compare_value);

  // counting sequence: normal wrap or phase correct up/down
  always @* begin
    next_counter        = counter_value;
    next_count_down     = count_down;
    next_overflow_event = 1'b0;
    if (timer_tick) begin
      if (phase_correct) begin
        if (count_down && counter_value == `TMR_BOTTOM) begin
          next_count_down     = 1'b0;
          next_counter        = counter_value + 8'h01;
          next_overflow_event = 1'b1;
        end else if (!count_down && counter_value == `TMR_MAX) begin
          next_count_down = 1'b1;
          next_counter    = counter_value - 8'h01;
        end else if (count_down) begin
          next_counter = counter_value - 8'h01;
        end else begin
          next_counter = counter_value + 8'h01;
        end
      end else begin
        next_counter        = counter_value + 8'h01;
        next_overflow_event = (counter_value == `TMR_MAX);
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_value <= `TMR_RST_BYTE;
      count_down    <= 1'b0;
      block_match   <= 1'b0;
      compare_match <= 1'b0;
    end else begin
      compare_match <= match_event;
      if (wr_count) begin
        counter_value <= pwdata[7:0];
        block_match   <= 1'b1;
      end else begin
        counter_value <= next_counter;
        if (timer_tick) begin
          block_match <= 1'b0;
        end
      end
      if (!phase_correct) begin
        count_down <= 1'b0;
      end else begin
        count_down <= next_count_down;
      end
    end
  end

  // flags: a set in the same cycle as a clear wins
  always @* begin
    next_overflow_flag = overflow_flag;
    next_compare_flag  = compare_flag;
    if (next_overflow_event) begin
      next_overflow_flag = 1'b1;
    end else if (ovf_clear) begin
      next_overflow_flag = 1'b0;
    end
    if (match_event) begin
      next_compare_flag = 1'b1;
    end else if (cmp_clear) begin
      next_compare_flag = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag <= 1'b0;
      compare_flag  <= 1'b0;
    end else begin
      overflow_flag <= next_overflow_flag;
      compare_flag  <= next_compare_flag;
    end
  end

  assign overflow_irq = timer_interrupt_mask[`TMR_BIT_OVF] & global_irq_en & overflow_flag;
  assign compare_irq  = timer_interrupt_mask[`TMR_BIT_CMP] & global_irq_en & compare_flag;

  // compare value and interrupt mask
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_value        <= `TMR_RST_BYTE;
      timer_interrupt_mask <= `TMR_RST_BYTE;
    end else begin
      if (wr_compare) begin
        compare_value <= pwdata[7:0];
      end
      if (wr_mask) begin
        timer_interrupt_mask <= pwdata[7:0];
      end
    end
  end

  // clock selector and counting sequence
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_selector <= `TMR_SEL_STOP;
      phase_correct  <= 1'b0;
    end else if (wr_ctrl) begin
      clock_selector <= pwdata[`TMR_SEL_MSB:0];
      phase_correct  <= pwdata[`TMR_BIT_PHASE];
    end
  end

  // prescaler reset bits: kept while holding, otherwise high for one cycle
  always @* begin
    next_hold         = sync_hold_mode;
    next_shared_reset = shared_reset_bit;
    next_async_reset  = async_reset_bit;
    if (wr_sfc) begin
      next_hold = pwdata[`TMR_BIT_HOLD];
      if (pwdata[`TMR_BIT_HOLD]) begin
        next_shared_reset = pwdata[`TMR_BIT_SHARED];
        next_async_reset  = pwdata[`TMR_BIT_ASYNC];
      end else if (sync_hold_mode) begin
        // leaving hold mode releases both resets so the timers start together
        next_shared_reset = 1'b0;
        next_async_reset  = 1'b0;
      end else begin
        next_shared_reset = pwdata[`TMR_BIT_SHARED];
        next_async_reset  = pwdata[`TMR_BIT_ASYNC];
      end
    end else if (!sync_hold_mode) begin
      next_shared_reset = 1'b0;
      next_async_reset  = 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_hold_mode   <= 1'b0;
      shared_reset_bit <= 1'b0;
      async_reset_bit  <= 1'b0;
    end else begin
      sync_hold_mode   <= next_hold;
      shared_reset_bit <= next_shared_reset;
      async_reset_bit  <= next_async_reset;
    end
  end

  // read data and error are captured in the setup cycle
  always @* begin
    next_rdata = `TMR_RST_WORD;
    next_err   = 1'b0;
    case (paddr)
      `TMR_ADDR_COUNT:   next_rdata[7:0] = counter_value;
      `TMR_ADDR_COMPARE: next_rdata[7:0] = compare_value;
      `TMR_ADDR_MASK:    next_rdata[7:0] = timer_interrupt_mask;
      `TMR_ADDR_FLAGS: begin
        next_rdata[`TMR_BIT_OVF] = overflow_flag;
        next_rdata[`TMR_BIT_CMP] = compare_flag;
      end
      `TMR_ADDR_SFC: begin
        next_rdata[`TMR_BIT_HOLD]   = sync_hold_mode;
        next_rdata[`TMR_BIT_ASYNC]  = async_reset_bit;
        next_rdata[`TMR_BIT_SHARED] = shared_reset_bit;
      end
      `TMR_ADDR_CTRL: begin
        next_rdata[`TMR_SEL_MSB:0]  = clock_selector;
        next_rdata[`TMR_BIT_PHASE]  = phase_correct;
      end
      default: next_err = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= `TMR_RST_WORD;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata  <= pwrite ? `TMR_RST_WORD : next_rdata;
      pslverr <= next_err;
    end
  end

endmodule

// ===== hw/tmr_consts.vh
`ifndef TMR_CONSTS_VH
`define TMR_CONSTS_VH

// register byte addresses
`define TMR_ADDR_COUNT    8'h00
`define TMR_ADDR_COMPARE  8'h04
`define TMR_ADDR_MASK     8'h08
`define TMR_ADDR_FLAGS    8'h0C
`define TMR_ADDR_SFC      8'h10
`define TMR_ADDR_CTRL     8'h14

// field positions
`define TMR_BIT_CMP       0
`define TMR_BIT_OVF       1
`define TMR_BIT_SHARED    0
`define TMR_BIT_ASYNC     1
`define TMR_BIT_HOLD      7
`define TMR_BIT_PHASE     3
`define TMR_SEL_MSB       2

// clock selector codes
`define TMR_SEL_STOP      3'h0
`define TMR_SEL_DIV1      3'h1
`define TMR_SEL_DIV8      3'h2
`define TMR_SEL_DIV64     3'h3
`define TMR_SEL_DIV256    3'h4
`define TMR_SEL_DIV1024   3'h5
`define TMR_SEL_EXT_FALL  3'h6
`define TMR_SEL_EXT_RISE  3'h7

// prescaler tap widths (log2 of divisor)
`define TMR_LOG_DIV8      3
`define TMR_LOG_DIV16     4
`define TMR_LOG_DIV32     5
`define TMR_LOG_DIV64     6
`define TMR_LOG_DIV256    8
`define TMR_LOG_DIV1024   10

// tap vector positions
`define TMR_TAP_1         0
`define TMR_TAP_8         1
`define TMR_TAP_16        2
`define TMR_TAP_32        3
`define TMR_TAP_64        4
`define TMR_TAP_256       5
`define TMR_TAP_1024      6
`define TMR_TAP_COUNT     7

// counter values and reset values
`define TMR_BOTTOM        8'h00
`define TMR_MAX           8'hFF
`define TMR_RST_BYTE      8'h00
`define TMR_RST_WORD      32'h00000000

`endif

// ===== dv/tmr_pin_model.sv
`timescale 1ns/1ps
module tmr_pin_model (
  input  wire       pclk,
  input  wire       start,
  input  wire [3:0] pulses,
  input  wire [3:0] half,
  output reg        pin,
  output reg        busy
);
  initial begin
    pin = 1'b0;
    busy = 1'b0;
  end
  // the pin rests low between bursts, so the source can be switched safely
  always @(posedge pclk) begin
    if (start) begin
      busy <= 1'b1;
      repeat (pulses) begin
        pin <= 1'b1;
        repeat (half) @(posedge pclk);
        pin <= 1'b0;
        repeat (half) @(posedge pclk);
      end
      busy <= 1'b0;
    end
  end
endmodule

// ===== dv/tmr_monitor.sv
`timescale 1ns/1ps
`include "tmr_consts.vh"
module tmr_monitor (
  input wire                      pclk,
  input wire                      presetn,
  input wire                      psel,
  input wire                      penable,
  input wire                      pwrite,
  input wire [7:0]                paddr,
  input wire [31:0]               pwdata,
  input wire                      global_irq_en,
  input wire                      overflow_irq,
  input wire                      compare_irq,
  input wire                      compare_match,
  input wire [`TMR_TAP_COUNT-1:0] prescale_taps,
  input wire                      shared_prescaler_reset,
  input wire                      async_prescaler_reset
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire sfc_wr = psel && penable && pwrite && paddr == `TMR_ADDR_SFC;
  wire held   = shared_prescaler_reset || async_prescaler_reset;

  ovf_irq_gate_a: assert property (!global_irq_en |-> !overflow_irq)
    else $error("overflow irq without global enable");
  cmp_irq_gate_a: assert property (!global_irq_en |-> !compare_irq)
    else $error("compare irq without global enable");
  tap_nest_a: assert property (prescale_taps[6] |-> &prescale_taps)
    else $error("slow tap without faster taps");
  tap_gap_a: assert property (prescale_taps[1] |=> !prescale_taps[1] [*7])
    else $error("div8 tap too early");
  tap_period_a: assert property
    (prescale_taps[1] ##1 !shared_prescaler_reset [*7] |=> prescale_taps[1] || shared_prescaler_reset)
    else $error("div8 tap missing");
  reset_taps_a: assert property (shared_prescaler_reset |-> prescale_taps == '0)
    else $error("tap while prescaler reset");
  self_clear_a: assert property
    (sfc_wr && !pwdata[7] && pwdata[0] && !held |=> shared_prescaler_reset ##1 !shared_prescaler_reset)
    else $error("shared reset not a one cycle pulse");
  hold_keep_a: assert property (sfc_wr && pwdata[7] && pwdata[0] |=> shared_prescaler_reset [*2])
    else $error("held reset bit dropped");
  release_a: assert property (sfc_wr && pwdata[7:0] == 8'h00 |=> !held)
    else $error("reset bits not cleared on release");
  match_pulse_a: assert property (compare_match |=> !compare_match)
    else $error("compare match longer than one cycle");
endmodule

bind tmr_timer0 tmr_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .global_irq_en,
  .overflow_irq, .compare_irq, .compare_match, .prescale_taps, .shared_prescaler_reset, .async_prescaler_reset);

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`include "tmr_consts.vh"
module tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic        global_irq_en = 1'b0;
  logic        overflow_vector_ack = 1'b0;
  logic        compare_vector_ack = 1'b0;
  logic        start = 1'b0;
  logic [3:0]  pulses = 4'h0;
  logic [3:0]  half = 4'h2;
  logic [31:0] prdata, q;
  logic [7:0]  counter_value;
  logic [6:0]  prescale_taps;
  logic        pready, pslverr, e, ext_count_pin, busy, overflow_irq, compare_irq, compare_match;
  logic        shared_prescaler_reset, async_prescaler_reset;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          match_seen = 0;

  always #2 pclk = ~pclk;

  // compare match pulses seen on the output
  always @(posedge pclk) begin
    if (compare_match === 1'b1) begin
      match_seen <= match_seen + 1;
    end
  end

  tmr_timer0 #(.PRESCALE_WIDTH(10)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ext_count_pin, .global_irq_en, .overflow_vector_ack, .compare_vector_ack,
    .overflow_irq, .compare_irq, .compare_match, .counter_value, .prescale_taps, .shared_prescaler_reset,
    .async_prescaler_reset);
  tmr_pin_model PIN (.pclk, .start, .pulses, .half, .pin(ext_count_pin), .busy);

  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  // cycles until the counter next moves, capped
  task gap(output int n);
    logic [7:0] v;
    #1;
    v = counter_value;
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (counter_value === v && n < 2100);
  endtask
  // burst on the count pin; n is cycles from first rise to first count
  task run(input logic [3:0] p, input logic [3:0] h, output int n);
    logic [7:0] v;
    v = counter_value;
    @(posedge pclk);
    pulses <= p;
    half <= h;
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    @(posedge ext_count_pin);
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (counter_value === v && n < 20);
    while (busy === 1'b1) @(posedge pclk);
    repeat (5) @(posedge pclk);
  endtask

  task t_regs;
    apb(1'b0, `TMR_ADDR_MASK, 32'h0);
    chk("mask reset", 0, q);
    apb(1'b0, `TMR_ADDR_FLAGS, 32'h0);
    chk("flags reset", 0, q);
    apb(1'b1, `TMR_ADDR_COMPARE, 32'h5A);
    apb(1'b0, `TMR_ADDR_COMPARE, 32'h0);
    chk("compare", 32'h5A, q);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped err", 1, e);
  endtask
  task t_div;
    int div [5] = '{1, 8, 64, 256, 1024};
    int n0, n;
    for (int s = 1; s <= 5; s++) begin
      apb(1'b1, `TMR_ADDR_CTRL, 32'(s));
      gap(n0);
      gap(n);
      chk("first tick", 1, n0 <= div[s-1] + 1);
      chk("tick period", div[s-1], n);
    end
    apb(1'b1, `TMR_ADDR_CTRL, 32'h0);
    gap(n);
    chk("stopped", 2100, n);
  endtask
  task t_flags;
    int n;
    apb(1'b1, `TMR_ADDR_FLAGS, 32'h3);
    apb(1'b1, `TMR_ADDR_MASK, 32'h3);
    apb(1'b1, `TMR_ADDR_COMPARE, 32'h20);
    apb(1'b1, `TMR_ADDR_COUNT, 32'hF0);
    @(posedge pclk);
    global_irq_en <= 1'b1;
    apb(1'b1, `TMR_ADDR_CTRL, 32'h1);
    n = 0;
    while (!(overflow_irq === 1'b1 && compare_irq === 1'b1) && n < 400) begin
      @(posedge pclk);
      n++;
    end
    apb(1'b1, `TMR_ADDR_CTRL, 32'h0);
    apb(1'b0, `TMR_ADDR_FLAGS, 32'h0);
    chk("both flags", 3, q);
    apb(1'b1, `TMR_ADDR_MASK, 32'h0);
    chk("masked irqs", 0, {overflow_irq, compare_irq});
    apb(1'b1, `TMR_ADDR_MASK, 32'h3);
    chk("unmasked irqs", 3, {overflow_irq, compare_irq});
    @(posedge pclk);
    global_irq_en <= 1'b0;
    #1;
    chk("global off", 0, {overflow_irq, compare_irq});
    @(posedge pclk);
    global_irq_en <= 1'b1;
    overflow_vector_ack <= 1'b1;
    @(posedge pclk);
    overflow_vector_ack <= 1'b0;
    #1;
    chk("vector clear", 1, {overflow_irq, compare_irq});
    apb(1'b1, `TMR_ADDR_FLAGS, 32'h1);
    apb(1'b0, `TMR_ADDR_FLAGS, 32'h0);
    chk("w1c clear", 0, q);
    apb(1'b1, `TMR_ADDR_COMPARE, 32'h0);
    apb(1'b1, `TMR_ADDR_COUNT, 32'hFF);
    apb(1'b1, `TMR_ADDR_CTRL, 32'h1);
    apb(1'b1, `TMR_ADDR_CTRL, 32'h0);
    @(posedge pclk);
    compare_vector_ack <= 1'b1;
    @(posedge pclk);
    compare_vector_ack <= 1'b0;
    #1;
    chk("cmp vector clear", 2, {overflow_irq, compare_irq});
    apb(1'b1, `TMR_ADDR_FLAGS, 32'h2);
    apb(1'b0, `TMR_ADDR_FLAGS, 32'h0);
    chk("ovf w1c clear", 0, q);
  endtask
  task t_block;
    int m;
    apb(1'b1, `TMR_ADDR_COMPARE, 32'h5);
    apb(1'b1, `TMR_ADDR_COUNT, 32'h80);
    for (int i = 0; i < 2; i++) begin
      m = match_seen;
      apb(1'b1, `TMR_ADDR_FLAGS, 32'h3);
      apb(1'b1, `TMR_ADDR_CTRL, 32'h1);
      apb(1'b1, `TMR_ADDR_COUNT, 32'(5 - i));
      apb(1'b1, `TMR_ADDR_CTRL, 32'h0);
      apb(1'b0, `TMR_ADDR_FLAGS, 32'h0);
      chk("match after write", 32'(i), q[0]);
      chk("match pulses", 32'(i), 32'(match_seen - m));
    end
  endtask
  task t_phase;
    int n;
    apb(1'b1, `TMR_ADDR_COUNT, 32'hFD);
    apb(1'b1, `TMR_ADDR_FLAGS, 32'h3);
    apb(1'b1, `TMR_ADDR_CTRL, 32'h9);
    repeat (6) @(posedge pclk);
    apb(1'b1, `TMR_ADDR_CTRL, 32'h8);
    apb(1'b0, `TMR_ADDR_FLAGS, 32'h0);
    chk("no ovf at top", 0, q[1]);
    chk("down count", 32'hF8, counter_value);
    apb(1'b1, `TMR_ADDR_CTRL, 32'h9);
    n = 0;
    while (overflow_irq !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    apb(1'b1, `TMR_ADDR_CTRL, 32'h8);
    apb(1'b0, `TMR_ADDR_FLAGS, 32'h0);
    chk("ovf at bottom", 1, q[1]);
  endtask
  task t_ext;
    int n;
    logic [7:0] v;
    apb(1'b1, `TMR_ADDR_CTRL, 32'h7);
    v = counter_value;
    run(4'h1, 4'h2, n);
    chk("rise latency", 3, n);
    chk("rise count", v + 8'h1, counter_value);
    apb(1'b1, `TMR_ADDR_SFC, 32'h83);
    chk("hold bits", 3, {async_prescaler_reset, shared_prescaler_reset});
    v = counter_value;
    run(4'h4, 4'h5, n);
    chk("held ext count", v + 8'h4, counter_value);
    apb(1'b1, `TMR_ADDR_CTRL, 32'h6);
    v = counter_value;
    run(4'h3, 4'h2, n);
    chk("fall latency", 5, n);
    chk("fall count", v + 8'h3, counter_value);
    apb(1'b1, `TMR_ADDR_SFC, 32'h00);
    chk("released", 0, {async_prescaler_reset, shared_prescaler_reset});
    apb(1'b1, `TMR_ADDR_SFC, 32'h01);
    apb(1'b0, `TMR_ADDR_SFC, 32'h0);
    chk("self clear", 0, q[0]);
  endtask

  task conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_div;
    t_flags;
    t_block;
    t_phase;
    t_ext;
    conclude;
  end
  initial begin
    repeat (40000) @(posedge pclk);
    error_cnt++;
    conclude;
  end
endmodule
